//--- core/kfc_pkg.sv
`default_nettype none
package kfc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] KFC_ADDR_CMD = 8'hb9;
  localparam logic [7:0] KFC_ADDR_ACCESS_KEY = 8'hba;
  localparam logic [7:0] KFC_ADDR_PROT_KEY = 8'hbb;
  localparam logic [7:0] KFC_ADDR_DATA = 8'hbc;
  localparam logic [7:0] KFC_ADDR_ADR_LOW = 8'hc6;
  localparam logic [7:0] KFC_ADDR_ADR_HIGH = 8'hc7;

  // ==========================================================
  // Values after reset, and values set by operations
  localparam logic [7:0] KFC_RST_CMD = 8'h00;
  localparam logic [7:0] KFC_RST_ACCESS_KEY = 8'hff;
  localparam logic [7:0] KFC_RST_PROT_KEY = 8'hff;
  localparam logic [7:0] KFC_RST_DATA = 8'h00;
  localparam logic [7:0] KFC_RST_ADR = 8'h00;
  localparam logic [7:0] KFC_PROT_KEY_CLEARED = 8'h00;
  localparam logic [7:0] KFC_ERASED = 8'hff;
  localparam logic [7:0] KFC_READ_BLOCKED = 8'h00;

  // ==========================================================
  // Commands and key
  localparam logic [7:0] KFC_ACCESS_KEY = 8'h3b;
  localparam logic [7:0] KFC_CMD_WRITE = 8'h01;
  localparam logic [7:0] KFC_CMD_ERASE_PAGE = 8'h02;
  localparam logic [7:0] KFC_CMD_ERASE_ALL = 8'h03;
  localparam logic [7:0] KFC_CMD_READ = 8'h04;
  localparam logic [7:0] KFC_CMD_PROTECT = 8'h08;

  // ==========================================================
  // Flash geometry and protection layout
  localparam int KFC_FLASH_BYTES = 63488;
  localparam logic [15:0] KFC_FLASH_END = 16'hf7ff;
  localparam logic [15:0] KFC_PAGE_LAST_OFS = 16'h01ff;
  localparam logic [15:0] KFC_PROT_BASE = 16'hf7eb;
  localparam logic [7:0] KFC_PROT_PAGE_HIGH = 8'hf7;
  localparam logic [7:0] KFC_PROT_LOW_MIN = 8'heb;
  localparam int KFC_PROT_BYTES = 21;
  localparam logic [4:0] KFC_PROT_LAST_IDX = 5'd20;
  localparam int KFC_RP_BYTE_IDX = 1;
  localparam int KFC_WP_BYTE_IDX = 5;
  localparam int KFC_LAST_PAGE = 123;

  // ==========================================================
  // Register bus request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } kfc_sfr_req_t;

endpackage
`default_nettype wire

//--- core/kfc_flash_mem.sv
`timescale 1ns/1ps
`default_nettype none
module kfc_flash_mem (
  input wire logic i_ref_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [15:0] i_code_addr,
  output logic [7:0] o_code_data
);
  import kfc_pkg::*;

  logic [7:0] mem_q [0:KFC_FLASH_BYTES-1];
  logic addr_ok;
  logic code_ok;

  assign addr_ok = (i_addr <= KFC_FLASH_END);
  assign code_ok = (i_code_addr <= KFC_FLASH_END);

  // ==========================================================
  // Array with registered read ports.
  always_ff @(posedge i_ref_clk) begin
    if (i_we && addr_ok) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= addr_ok ? mem_q[i_addr] : KFC_ERASED;
    o_code_data <= code_ok ? mem_q[i_code_addr] : KFC_ERASED;
  end

endmodule
`default_nettype wire

//--- core/kfc_prot_map.sv
`timescale 1ns/1ps
`default_nettype none
module kfc_prot_map (
  input wire logic [8*kfc_pkg::KFC_PROT_BYTES-1:0] i_prot,
  input wire logic [6:0] i_page,
  output logic o_active,
  output logic o_wp_hit,
  output logic o_rp_hit
);
  import kfc_pkg::*;

  logic [127:0] wp_bits;
  logic [31:0] rp_bits;

  assign wp_bits = i_prot[8*KFC_WP_BYTE_IDX +: 128];
  assign rp_bits = i_prot[8*KFC_RP_BYTE_IDX +: 32];
  assign o_active = ~wp_bits[KFC_LAST_PAGE];
  assign o_wp_hit = o_active & ~wp_bits[i_page];
  assign o_rp_hit = o_active & ~rp_bits[i_page[6:2]];

endmodule
`default_nettype wire

//--- core/kfc_flash_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module kfc_flash_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire kfc_pkg::kfc_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_core_stall,
  output logic o_irq_hold,
  input wire logic [15:0] i_code_addr,
  output logic [7:0] o_code_data
);
  import kfc_pkg::*;

  typedef enum logic [3:0] {
    ST_LOAD_RD, ST_LOAD_CAP, ST_IDLE, ST_RMW_RD, ST_RMW_WR,
    ST_ERASE, ST_RD_WAIT, ST_RD_CAP, ST_DONE
  } kfc_state_t;

  // ==========================================================
  // Registers
  kfc_state_t state_q, state_d;
  logic [7:0] cmd_q, key_q, pk_q, data_q, adrl_q, adrh_q;
  logic [8*KFC_PROT_BYTES-1:0] prot_q;
  logic [4:0] ld_idx_q;
  logic [15:0] op_addr_q, cnt_q, cnt_last_q;
  logic [7:0] op_wdata_q;
  logic op_key_byte_q, rd_blocked_q;
  logic stall_q, irq_hold_q;
  logic [7:0] rdata_q;
  logic [15:0] erase_run_q;

  // ==========================================================
  // Decode
  logic idle, sfr_wr, cmd_wr, key_ok, known_cmd, start;
  logic [15:0] cur_addr, prot_addr, map_addr, mem_addr, erase_addr;
  logic in_range, in_prot_area, prot_low_ok, prot_key_ok;
  logic active, wp_hit, rp_hit;
  logic write_ok, erase_ok, protect_ok;
  logic [7:0] stored_key, mem_rdata, mem_wdata, rd_mux;
  logic mem_we, rmw_ok, erase_last;

  assign idle = (state_q == ST_IDLE);
  assign sfr_wr = i_sfr.wr && idle;
  assign cmd_wr = sfr_wr && (i_sfr.addr == KFC_ADDR_CMD);
  assign key_ok = (key_q == KFC_ACCESS_KEY);
  assign known_cmd = (i_sfr.wdata == KFC_CMD_WRITE) || (i_sfr.wdata == KFC_CMD_ERASE_PAGE) ||
                     (i_sfr.wdata == KFC_CMD_ERASE_ALL) || (i_sfr.wdata == KFC_CMD_READ) ||
                     (i_sfr.wdata == KFC_CMD_PROTECT);
  assign start = cmd_wr && key_ok && known_cmd;

  assign cur_addr = {adrh_q, adrl_q};
  assign prot_addr = {KFC_PROT_PAGE_HIGH, adrl_q};
  assign prot_low_ok = (adrl_q >= KFC_PROT_LOW_MIN);
  assign map_addr = (i_sfr.wdata == KFC_CMD_PROTECT) ? prot_addr : cur_addr;
  assign in_range = (cur_addr <= KFC_FLASH_END);
  assign in_prot_area = in_range && (cur_addr >= KFC_PROT_BASE);
  assign stored_key = prot_q[7:0];
  // Stored key check, skipped while erased.
  assign prot_key_ok = (stored_key == KFC_ERASED) || (pk_q == stored_key);

  kfc_prot_map u_prot_map (
    .i_prot(prot_q),
    .i_page(map_addr[15:9]),
    .o_active(active),
    .o_wp_hit(wp_hit),
    .o_rp_hit(rp_hit)
  );

  assign write_ok = in_range && !in_prot_area && !wp_hit;
  assign erase_ok = in_range && !wp_hit;
  assign protect_ok = prot_low_ok && prot_key_ok;

  // ==========================================================
  // Flash port
  assign erase_addr = op_addr_q + cnt_q;
  assign mem_addr = (state_q == ST_ERASE) ? erase_addr :
                    (state_q == ST_LOAD_RD) ? KFC_PROT_BASE + {11'h000, ld_idx_q} : op_addr_q;
  // Key byte only while still erased.
  assign rmw_ok = !op_key_byte_q || (mem_rdata == KFC_ERASED);
  assign mem_we = (state_q == ST_ERASE) || ((state_q == ST_RMW_WR) && rmw_ok);
  assign mem_wdata = (state_q == ST_ERASE) ? KFC_ERASED : (mem_rdata & op_wdata_q);
  assign erase_last = (cnt_q == cnt_last_q);

  kfc_flash_mem u_mem (
    .i_ref_clk(i_ref_clk),
    .i_addr(mem_addr),
    .i_we(mem_we),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata),
    .i_code_addr(i_code_addr),
    .o_code_data(o_code_data)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD_RD: state_d = ST_LOAD_CAP;
      ST_LOAD_CAP: state_d = (ld_idx_q == KFC_PROT_LAST_IDX) ? ST_IDLE : ST_LOAD_RD;
      ST_IDLE: begin
        if (start) begin
          unique case (i_sfr.wdata)
            KFC_CMD_WRITE: state_d = write_ok ? ST_RMW_RD : ST_DONE;
            KFC_CMD_ERASE_PAGE: state_d = erase_ok ? ST_ERASE : ST_DONE;
            KFC_CMD_ERASE_ALL: state_d = ST_ERASE;
            KFC_CMD_READ: state_d = ST_RD_WAIT;
            default: state_d = protect_ok ? ST_RMW_RD : ST_DONE;
          endcase
        end
      end
      ST_RMW_RD: state_d = ST_RMW_WR;
      ST_RMW_WR: state_d = ST_DONE;
      ST_ERASE: state_d = erase_last ? ST_DONE : ST_ERASE;
      ST_RD_WAIT: state_d = ST_RD_CAP;
      ST_RD_CAP: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_LOAD_RD;
      stall_q <= 1'b1;
      irq_hold_q <= 1'b1;
    end else begin
      state_q <= state_d;
      stall_q <= (state_d != ST_IDLE);
      irq_hold_q <= (state_d != ST_IDLE);
    end
  end

  // Protection shadow loaded after reset only.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prot_q <= '1;
      ld_idx_q <= 5'd0;
    end else if (state_q == ST_LOAD_CAP) begin
      prot_q[8*ld_idx_q +: 8] <= mem_rdata;
      ld_idx_q <= ld_idx_q + 5'd1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_addr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      cnt_last_q <= 16'h0000;
      op_wdata_q <= 8'h00;
      op_key_byte_q <= 1'b0;
      rd_blocked_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 16'h0000;
      op_key_byte_q <= (i_sfr.wdata == KFC_CMD_PROTECT) && (prot_addr == KFC_PROT_BASE);
      rd_blocked_q <= rp_hit && !in_prot_area;
      op_wdata_q <= ((i_sfr.wdata == KFC_CMD_PROTECT) && (prot_addr == KFC_PROT_BASE)) ?
                    pk_q : data_q;
      if (i_sfr.wdata == KFC_CMD_ERASE_ALL) begin
        op_addr_q <= 16'h0000;
        cnt_last_q <= KFC_FLASH_END;
      end else if (i_sfr.wdata == KFC_CMD_ERASE_PAGE) begin
        op_addr_q <= {cur_addr[15:9], 9'h000};
        cnt_last_q <= KFC_PAGE_LAST_OFS;
      end else begin
        op_addr_q <= (i_sfr.wdata == KFC_CMD_PROTECT) ? prot_addr : cur_addr;
        cnt_last_q <= 16'h0000;
      end
    end else if (state_q == ST_ERASE) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_q <= KFC_RST_CMD;
      key_q <= KFC_RST_ACCESS_KEY;
      pk_q <= KFC_RST_PROT_KEY;
      data_q <= KFC_RST_DATA;
      adrl_q <= KFC_RST_ADR;
      adrh_q <= KFC_RST_ADR;
    end else begin
      if (sfr_wr && (i_sfr.addr == KFC_ADDR_CMD)) begin
        cmd_q <= i_sfr.wdata;
      end
      if (state_q == ST_DONE) begin
        key_q <= KFC_RST_ACCESS_KEY;
      end else if (sfr_wr && (i_sfr.addr == KFC_ADDR_ACCESS_KEY)) begin
        key_q <= i_sfr.wdata;
      end
      if (start && (i_sfr.wdata == KFC_CMD_PROTECT)) begin
        pk_q <= KFC_PROT_KEY_CLEARED;
      end else if (sfr_wr && (i_sfr.addr == KFC_ADDR_PROT_KEY)) begin
        pk_q <= i_sfr.wdata;
      end
      if (state_q == ST_RD_CAP) begin
        data_q <= rd_blocked_q ? KFC_READ_BLOCKED : mem_rdata;
      end else if (sfr_wr && (i_sfr.addr == KFC_ADDR_DATA)) begin
        data_q <= i_sfr.wdata;
      end
      if (sfr_wr && (i_sfr.addr == KFC_ADDR_ADR_LOW)) begin
        adrl_q <= i_sfr.wdata;
      end
      if (sfr_wr && (i_sfr.addr == KFC_ADDR_ADR_HIGH)) begin
        adrh_q <= i_sfr.wdata;
      end
    end
  end

  // ==========================================================
  // Register read
  assign rd_mux = (i_sfr.addr == KFC_ADDR_CMD) ? cmd_q :
                  (i_sfr.addr == KFC_ADDR_ACCESS_KEY) ? key_q :
                  (i_sfr.addr == KFC_ADDR_PROT_KEY) ? pk_q :
                  (i_sfr.addr == KFC_ADDR_DATA) ? data_q :
                  (i_sfr.addr == KFC_ADDR_ADR_LOW) ? adrl_q :
                  (i_sfr.addr == KFC_ADDR_ADR_HIGH) ? adrh_q : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 8'h00;
    end else if (i_sfr.rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_core_stall = stall_q;
  assign o_irq_hold = irq_hold_q;

  // Counts the cycles already spent in the running erase.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      erase_run_q <= 16'h0000;
    end else if (state_q == ST_ERASE) begin
      erase_run_q <= erase_run_q + 16'h0001;
    end else begin
      erase_run_q <= 16'h0000;
    end
  end

  // ==========================================================
  // Checks
  stall_on_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    start |=> o_core_stall)
    else $error("accepted command did not stall the core");

  key_mismatch_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (cmd_wr && !key_ok) |=> !o_core_stall)
    else $error("command ran without access key");

  reserved_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (cmd_wr && (i_sfr.wdata >= 8'h05) && (i_sfr.wdata <= 8'h07)) |=> !o_core_stall)
    else $error("reserved command stalled the core");

  key_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $fell(o_core_stall) && (ld_idx_q == 5'd21) |-> (key_q == KFC_RST_ACCESS_KEY))
    else $error("access key not reset after operation");

  irq_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_irq_hold == o_core_stall)
    else $error("interrupt hold differs from stall");

  protkey_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (start && (i_sfr.wdata == KFC_CMD_PROTECT)) |=> (pk_q == KFC_PROT_KEY_CLEARED))
    else $error("protection key entry not cleared");

  clear_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (mem_we && (state_q == ST_RMW_WR)) |-> ((mem_wdata & ~mem_rdata) == 8'h00))
    else $error("programming set a bit");

  prot_area_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (start && (i_sfr.wdata == KFC_CMD_WRITE) && in_prot_area) |=> (state_q == ST_DONE))
    else $error("write byte reached protection area");

  page_erase_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (start && (i_sfr.wdata == KFC_CMD_ERASE_PAGE) && erase_ok) |=>
    (state_q == ST_ERASE) [*8])
    else $error("page erase did not start");

  erase_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    ((state_q == ST_ERASE) && (state_d != ST_ERASE)) |->
    (erase_run_q == ((cmd_q == KFC_CMD_ERASE_PAGE) ? KFC_PAGE_LAST_OFS : KFC_FLASH_END)))
    else $error("erase length wrong");

  read_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (start && (i_sfr.wdata == KFC_CMD_READ)) |=> ##2 (data_q == ($past(rd_blocked_q) ?
    KFC_READ_BLOCKED : $past(mem_rdata))) ##1 !o_core_stall)
    else $error("read byte result or timing wrong");

endmodule
`default_nettype wire

//--- verif/kfc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module kfc_core_model (
  input wire logic i_ref_clk,
  input wire logic i_stall,
  input wire logic i_irq_hold,
  input wire logic [7:0] i_rdata,
  output kfc_pkg::kfc_sfr_req_t o_sfr
);
  import kfc_pkg::*;

  initial begin
    o_sfr = '0;
  end

  // ==========================================================
  // Bus cycles
  // no fetch while held
  task automatic wait_run();
    int n;
    n = 0;
    while (i_stall !== 1'b0 && n < 200) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    wait_run();
    @(posedge i_ref_clk);
    o_sfr.addr <= a;
    o_sfr.wdata <= d;
    o_sfr.wr <= 1'b1;
    @(posedge i_ref_clk);
    o_sfr.wr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    wait_run();
    @(posedge i_ref_clk);
    o_sfr.addr <= a;
    o_sfr.rd <= 1'b1;
    @(posedge i_ref_clk);
    o_sfr.rd <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    d = i_rdata;
  endtask

  // ==========================================================
  // Commands
  // count held cycles, interrupts held alike
  task automatic raw_cmd(input logic [7:0] c, output int n, output bit ok);
    sfr_wr(KFC_ADDR_CMD, c);
    n = 0;
    ok = 1'b1;
    #1;
    while (i_stall === 1'b1 && n < 70000) begin
      if (i_irq_hold !== i_stall) ok = 1'b0;
      n++;
      @(posedge i_ref_clk);
      #1;
    end
    if (i_irq_hold !== i_stall) ok = 1'b0;
  endtask

  task automatic run_cmd(input logic [7:0] c, output int n, output bit ok);
    sfr_wr(KFC_ADDR_ACCESS_KEY, KFC_ACCESS_KEY);
    raw_cmd(c, n, ok);
  endtask
endmodule
`default_nettype wire

//--- verif/kfc_flash_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module kfc_flash_ctrl_tb;
  import kfc_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wv;
    logic [7:0] rst;
    logic [7:0] rb;
  } kfc_row_t;
  logic clk = 1'b0;
  logic arst_n;
  logic [15:0] code_addr;
  logic [7:0] code_data, rdata;
  logic stall, irq_hold;
  kfc_sfr_req_t sfr;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  bit ok_raw;
  kfc_row_t rows [7] = '{'{8'hb9, 8'h06, 8'h00, 8'h06}, '{8'hba, 8'h5a, 8'hff, 8'h5a},
    '{8'hbb, 8'ha5, 8'hff, 8'ha5}, '{8'hbc, 8'hc3, 8'h00, 8'hc3},
    '{8'hc6, 8'h11, 8'h00, 8'h11}, '{8'hc7, 8'h22, 8'h00, 8'h22}, '{8'hbd, 8'h77, 8'h00, 8'h00}};

  always #25 clk = ~clk;

  kfc_flash_ctrl u_dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .o_core_stall(stall), .o_irq_hold(irq_hold), .i_code_addr(code_addr),
    .o_code_data(code_data));
  kfc_core_model u_core (.i_ref_clk(clk), .i_stall(stall), .i_irq_hold(irq_hold),
    .i_rdata(rdata), .o_sfr(sfr));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fcmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    bit ok;
    u_core.sfr_wr(KFC_ADDR_ADR_HIGH, a[15:8]);
    u_core.sfr_wr(KFC_ADDR_ADR_LOW, a[7:0]);
    u_core.sfr_wr(KFC_ADDR_DATA, d);
    u_core.run_cmd(c, n, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  task automatic regchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_core.sfr_rd(a, d);
    chk({24'h0, d}, {24'h0, e});
  endtask

  task automatic fchk(input logic [15:0] a, input logic [7:0] e);
    fcmd(a, 8'h00, KFC_CMD_READ);
    regchk(KFC_ADDR_DATA, e);
  endtask

  task automatic codechk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    code_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk({24'h0, code_data}, {24'h0, e});
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk({31'h0, stall}, 32'h1);
    @(posedge clk);
    arst_n <= 1'b1;
    u_core.wait_run();
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 32'h1, 32'h0);
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    code_addr = 16'h0000;
    do_reset();
    foreach (rows[i]) begin
      regchk(rows[i].addr, rows[i].rst);
      u_core.sfr_wr(rows[i].addr, rows[i].wv);
      regchk(rows[i].addr, rows[i].rb);
    end
    $display("registers done");
    fcmd(16'h0000, 8'h00, KFC_CMD_ERASE_ALL);
    chk(n, 32'd63489);
    do_reset();
    fchk(16'hf7ff, 8'hff);
    codechk(16'h0010, 8'hff);
    $display("erase all done");
    fcmd(16'h3c00, 8'hf3, KFC_CMD_WRITE);
    chk(n, 32'd3);
    regchk(KFC_ADDR_ACCESS_KEY, 8'hff);
    fchk(16'h3c00, 8'hf3);
    codechk(16'h3c00, 8'hf3);
    fcmd(16'h3c00, 8'h0f, KFC_CMD_WRITE);
    fchk(16'h3c00, 8'h03);
    fcmd(16'h3e00, 8'h55, KFC_CMD_WRITE);
    fcmd(16'h3c1f, 8'h00, KFC_CMD_ERASE_PAGE);
    chk(n, 32'd513);
    fchk(16'h3c00, 8'hff);
    fchk(16'h3e00, 8'h55);
    u_core.sfr_wr(KFC_ADDR_DATA, 8'h12);
    u_core.raw_cmd(KFC_CMD_WRITE, n, ok_raw);
    chk({31'h0, ok_raw}, 32'h1);
    chk(n, 32'd0);
    fchk(16'h3e00, 8'h55);
    for (int c = 5; c < 8; c++) begin
      u_core.sfr_wr(KFC_ADDR_ACCESS_KEY, KFC_ACCESS_KEY);
      u_core.raw_cmd(8'(c), n, ok_raw);
      chk({31'h0, ok_raw}, 32'h1);
      chk(n, 32'd0);
      regchk(KFC_ADDR_ACCESS_KEY, KFC_ACCESS_KEY);
    end
    fcmd(16'hf7f0, 8'h00, KFC_CMD_WRITE);
    chk(n, 32'd1);
    fchk(16'hf7f0, 8'hff);
    $display("commands done");
    fcmd(16'hf7f0, 8'hfe, KFC_CMD_PROTECT);
    regchk(KFC_ADDR_PROT_KEY, KFC_PROT_KEY_CLEARED);
    do_reset();
    fcmd(16'h0010, 8'h11, KFC_CMD_WRITE);
    fchk(16'h0010, 8'h11);
    fcmd(16'hf7ff, 8'hf7, KFC_CMD_PROTECT);
    fcmd(16'hf7ec, 8'hfe, KFC_CMD_PROTECT);
    fchk(16'hf7ff, 8'hf7);
    u_core.sfr_wr(KFC_ADDR_PROT_KEY, 8'ha3);
    fcmd(16'hf7eb, 8'h00, KFC_CMD_PROTECT);
    fchk(16'hf7eb, 8'ha3);
    fcmd(16'h0020, 8'h22, KFC_CMD_WRITE);
    fchk(16'h0020, 8'h22);
    $display("protection setup done");
    do_reset();
    fcmd(16'h0030, 8'h33, KFC_CMD_WRITE);
    codechk(16'h0030, 8'hff);
    fchk(16'h0010, KFC_READ_BLOCKED);
    fcmd(16'h0000, 8'h00, KFC_CMD_ERASE_PAGE);
    chk(n, 32'd1);
    codechk(16'h0010, 8'h11);
    fchk(16'hf7f0, 8'hfe);
    u_core.sfr_wr(KFC_ADDR_PROT_KEY, 8'h5a);
    fcmd(16'hf7f1, 8'hfe, KFC_CMD_PROTECT);
    fchk(16'hf7f1, 8'hff);
    u_core.sfr_wr(KFC_ADDR_PROT_KEY, 8'ha3);
    fcmd(16'hf7f1, 8'hfe, KFC_CMD_PROTECT);
    fchk(16'hf7f1, 8'hfe);
    $display("protection checks done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
